// file: gst_pkg.sv
/*
 * Package of the gated sixteen-bit timer: register map, field positions,
 * reset values, selector encodings and timing constants.
 * Assumes a single 25 MHz clock domain and a plain strobe register port.
 */
// Behaviour
// RQ1: Sixteen-bit up-counter; a write to either byte replaces that byte.
// RQ2: Off while on bit clear; gate enable clear counts always, else gated.
// RQ3: Clock select 11 slow oscillator, 10 pin clock, 01 system, 00 system/4.
// RQ4: System clock source advances count four times per instruction cycle.
// RQ5: Pin clock counts on rising edges, synchronised or used asynchronously. Here the pin always passes the two-stage synchroniser.
// RQ6: After enable, write or stop, a falling pin edge must precede counting.
// RQ7: Two-bit prescale divides chosen clock by 1, 2, 4 or 8.
// RQ8: Prescale counter hidden from software, cleared on any count byte write.
// RQ9: Sync-disable bit feeds pin clock without phase alignment.
// RQ10: Asynchronous pin clock counts in sleep; overflow raises interrupt. No sleep here: pin clock counts only on clk with ce high.
// RQ11: Switching sync mode may lose or add one increment.
// RQ12: Byte reads return valid values while counting asynchronously.
// RQ13: Software should stop counter before writing in asynchronous mode.
// RQ14: With gate enable, count only while gate active, else hold.
// RQ15: Gate polarity 0 counts on gate low, 1 counts on gate high.
// RQ16: Gate source 00 pin, 01 eight-bit wrap, 10 comp 1, 11 comp 2.
// RQ17: Eight-bit timer wrap from FFh to 00h gives a gate pulse.
// RQ18: Counter wraps FFFFh to 0000h and sets the overflow flag.
// RQ19: Count advances one per prescaler pulse while enabled and gated.
package gst_pkg;
    localparam logic [2:0] ADDR_COUNT_LOW = 3'h0;
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h1;
    localparam logic [2:0] ADDR_COUNTER_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_GATE_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;

    localparam int CTRL_ON_POS = 0;
    localparam int CTRL_SYNC_DIS_POS = 2;
    localparam int CTRL_PRESCALE_POS = 4;
    localparam int CTRL_CLKSEL_POS = 6;
    localparam int GATE_SRC_POS = 0;
    localparam int GATE_POL_POS = 6;
    localparam int GATE_EN_POS = 7;
    localparam int IRQ_OVF_POS = 0;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    typedef enum logic [1:0] {
        CLK_INSTR = 2'b00,
        CLK_SYSTEM = 2'b01,
        CLK_PIN = 2'b10,
        CLK_SLOW_OSC = 2'b11
    } gst_clksel_type;

    typedef enum logic [1:0] {
        GSRC_PIN = 2'b00,
        GSRC_EIGHT_BIT_WRAP = 2'b01,
        GSRC_CMP1 = 2'b10,
        GSRC_CMP2 = 2'b11
    } gst_gatesrc_type;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gst_bus_req_type;

    typedef struct packed {
        logic ext_clock_pin;
        logic gate_pin;
        logic comparator1_out;
        logic comparator2_out;
        logic low_freq_internal_osc;
    } gst_pins_type;
endpackage : gst_pkg

// file: gst_sync.sv
/*
 * Two-stage synchroniser bank for pin-level inputs.
 * Assumes inputs are asynchronous to clk; only the second stage is used.
 */
module gst_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            q <= '0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : gst_sync

// file: gst_timer.sv
/*
 * Gated sixteen-bit timer: clock selection, prescaler, gate logic,
 * counter with overflow interrupt and a strobe register port.
 * Assumes one clock domain; pin inputs are asynchronous and synchronised
 * here. The slow oscillator arrives as a level and is edge-detected.
 */
// Added by the designer: the placing of the registers and the strobed register port.
module gst_timer (
    // Clock, enable, reset
    input wire logic clk,
    input wire logic ce,
    input wire logic nrst,
    // Register port
    input wire gst_pkg::gst_bus_req_type bus,
    output logic [7:0] rdata,
    // Pins and neighbour signals
    input wire gst_pkg::gst_pins_type pins,
    input wire logic eight_bit_timer_wrap,
    // Interrupt
    output logic irq
);
    logic [7:0] ctrl_q;
    logic [7:0] gate_q;
    logic [7:0] mask_q;
    logic [7:0] status_q;
    logic [15:0] count_q;
    logic [2:0] pre_q;
    logic [1:0] idiv_q;
    logic pin_prev_q;
    logic pin_old_q;
    logic osc_prev_q;
    logic armed_q;
    logic on_prev_q;
    logic wrap_gate_q;
    logic [4:0] pins_s;
    logic pin_clk_s;
    logic gate_pin_s;
    logic cmp1_s;
    logic cmp2_s;
    logic osc_s;
    logic counter_on;
    logic sync_disable;
    logic [1:0] prescale_select;
    gst_pkg::gst_clksel_type clock_select;
    logic gate_enable;
    logic gate_polarity;
    gst_pkg::gst_gatesrc_type gate_source_select;
    logic wr_low;
    logic wr_high;
    logic count_write;
    logic src_tick;
    logic pin_rise;
    logic gate_raw;
    logic gate_open;
    logic run;
    logic pre_tick;
    logic inc;
    logic ovf;
    logic [2:0] pre_mask;

    gst_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d(pins),
        .q(pins_s)
    );
    assign {pin_clk_s, gate_pin_s, cmp1_s, cmp2_s, osc_s} = pins_s;

    assign counter_on = ctrl_q[gst_pkg::CTRL_ON_POS];
    assign sync_disable = ctrl_q[gst_pkg::CTRL_SYNC_DIS_POS];
    assign prescale_select = ctrl_q[gst_pkg::CTRL_PRESCALE_POS +: 2];
    assign clock_select = gst_pkg::gst_clksel_type'(
        ctrl_q[gst_pkg::CTRL_CLKSEL_POS +: 2]);
    assign gate_enable = gate_q[gst_pkg::GATE_EN_POS];
    assign gate_polarity = gate_q[gst_pkg::GATE_POL_POS];
    assign gate_source_select = gst_pkg::gst_gatesrc_type'(
        gate_q[gst_pkg::GATE_SRC_POS +: 2]);

    assign wr_low = bus.wr && bus.addr == gst_pkg::ADDR_COUNT_LOW;
    assign wr_high = bus.wr && bus.addr == gst_pkg::ADDR_COUNT_HIGH;
    assign count_write = wr_low || wr_high;

    // Control registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= gst_pkg::CTRL_RESET;
            gate_q <= gst_pkg::GATE_RESET;
            mask_q <= gst_pkg::MASK_RESET;
        end else if (ce && bus.wr) begin
            case (bus.addr)
                gst_pkg::ADDR_COUNTER_CONTROL: ctrl_q <= bus.wdata & 8'hF5;
                gst_pkg::ADDR_GATE_CONTROL: gate_q <= bus.wdata & 8'hC3;
                gst_pkg::ADDR_IRQ_MASK: mask_q <= bus.wdata & 8'h01;
                default: ;
            endcase
        end
    end

    // Instruction clock is system clock divided by four
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idiv_q <= '0;
        end else if (ce) begin
            idiv_q <= idiv_q + 2'h1;
        end
    end

    // Edge history of the pin clock and slow oscillator
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_prev_q <= 1'b0;
            pin_old_q <= 1'b0;
            osc_prev_q <= 1'b0;
            on_prev_q <= 1'b0;
        end else if (ce) begin
            pin_prev_q <= pin_clk_s;
            pin_old_q <= pin_prev_q;
            osc_prev_q <= osc_s;
            on_prev_q <= counter_on;
        end
    end

    // First rising edge needs a prior falling edge after enable, write, stop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            armed_q <= 1'b0;
        end else if (ce) begin
            if (count_write || !counter_on || !on_prev_q) begin
                armed_q <= 1'b0; // [RQ6]
            end else if (pin_prev_q && !pin_clk_s) begin
                armed_q <= 1'b1; // [RQ6]
            end
        end
    end

    // Pin rising edge; sync-disable takes the edge without an extra phase
    // stage. Either way the pin has passed the synchroniser, so a mode
    // switch can shift the edge by at most one sample. [RQ9] [RQ11]
    assign pin_rise = armed_q && (sync_disable
        ? (pin_clk_s && !pin_prev_q)
        : (pin_prev_q && !pin_old_q)); // [RQ5] [RQ9]

    always_comb begin
        case (clock_select)
            gst_pkg::CLK_SLOW_OSC: src_tick = osc_s && !osc_prev_q; // [RQ3]
            gst_pkg::CLK_PIN: src_tick = pin_rise; // [RQ3] [RQ5]
            gst_pkg::CLK_SYSTEM: src_tick = 1'b1; // [RQ3] [RQ4]
            gst_pkg::CLK_INSTR: src_tick =
                idiv_q == gst_pkg::INSTR_DIV_LAST; // [RQ3]
            default: src_tick = 1'b0;
        endcase
    end

    // Gate source and polarity
    always_comb begin
        case (gate_source_select)
            gst_pkg::GSRC_PIN: gate_raw = gate_pin_s; // [RQ16]
            gst_pkg::GSRC_EIGHT_BIT_WRAP: gate_raw = wrap_gate_q; // [RQ16]
            gst_pkg::GSRC_CMP1: gate_raw = cmp1_s; // [RQ16]
            gst_pkg::GSRC_CMP2: gate_raw = cmp2_s; // [RQ16]
            default: gate_raw = 1'b0;
        endcase
    end

    // Wrap of the companion timer registered; the gate follows its level one cycle late
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrap_gate_q <= 1'b0;
        end else if (ce) begin
            wrap_gate_q <= eight_bit_timer_wrap; // [RQ17]
        end
    end

    assign gate_open = (gate_raw == gate_polarity); // [RQ15]
    assign run = counter_on && (!gate_enable || gate_open); // [RQ2] [RQ14]

    // Prescaler: hidden, cleared on count writes
    always_comb begin
        case (prescale_select)
            2'b00: pre_mask = 3'h0;
            2'b01: pre_mask = 3'h1;
            2'b10: pre_mask = 3'h3;
            default: pre_mask = 3'h7;
        endcase
    end
    assign pre_tick = src_tick && ((pre_q & pre_mask) == pre_mask); // [RQ7]
    assign inc = run && pre_tick; // [RQ19]
    assign ovf = inc && count_q == gst_pkg::COUNT_MAX; // [RQ18]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_q <= '0;
        end else if (ce) begin
            if (count_write) begin
                pre_q <= '0; // [RQ8]
            end else if (run && src_tick) begin
                pre_q <= pre_q + 3'h1; // [RQ7]
            end
        end
    end

    // Main count; a byte write wins over an increment in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= gst_pkg::COUNT_RESET;
        end else if (ce) begin
            if (wr_low) begin
                count_q[7:0] <= bus.wdata; // [RQ1] [RQ13]
            end else if (wr_high) begin
                count_q[15:8] <= bus.wdata; // [RQ1]
            end else if (inc) begin
                count_q <= count_q + 16'h0001; // [RQ1] [RQ18] [RQ10]
            end
        end
    end

    // Overflow status: set wins over the read clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= 8'h00;
        end else if (ce) begin
            if (ovf) begin
                status_q[gst_pkg::IRQ_OVF_POS] <= 1'b1; // [RQ18]
            end else if (bus.rd && bus.addr == gst_pkg::ADDR_IRQ_STATUS) begin
                status_q <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |((status_q | {7'h00, ovf}) & mask_q); // [RQ10]
        end
    end

    // Read data in the cycle after the strobe, stable count snapshot
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= 8'h00;
            if (bus.rd) begin
                case (bus.addr)
                    gst_pkg::ADDR_COUNT_LOW: rdata <= count_q[7:0]; // [RQ12]
                    gst_pkg::ADDR_COUNT_HIGH: rdata <= count_q[15:8]; // [RQ12]
                    gst_pkg::ADDR_COUNTER_CONTROL: rdata <= ctrl_q;
                    gst_pkg::ADDR_GATE_CONTROL: rdata <= gate_q;
                    gst_pkg::ADDR_IRQ_STATUS: rdata <= status_q;
                    gst_pkg::ADDR_IRQ_MASK: rdata <= mask_q;
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end

    property p_count_low_write;
        @(posedge clk) disable iff (!nrst)
        (ce && wr_low) |=> count_q[7:0] == $past(bus.wdata);
    endproperty
    a_count_low_write: assert property (p_count_low_write) // [RQ1]
        else $error("count low byte write lost");

    property p_off_holds;
        @(posedge clk) disable iff (!nrst)
        (ce && !counter_on && !count_write) |=> $stable(count_q);
    endproperty
    a_off_holds: assert property (p_off_holds) // [RQ2]
        else $error("counter moved while off");

    property p_gate_closed_holds;
        @(posedge clk) disable iff (!nrst)
        (ce && gate_enable && !gate_open && !count_write)
            |=> $stable(count_q);
    endproperty
    a_gate_closed_holds: assert property (p_gate_closed_holds) // [RQ14] [RQ15]
        else $error("counter moved with gate closed");

    property p_system_rate;
        @(posedge clk) disable iff (!nrst)
        (ce && run && clock_select == gst_pkg::CLK_SYSTEM
            && prescale_select == 2'b00 && !count_write)
            |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_system_rate: assert property (p_system_rate) // [RQ3] [RQ4]
        else $error("system clock source did not count every cycle");

    property p_prescaler_cleared;
        @(posedge clk) disable iff (!nrst)
        (ce && count_write) |=> pre_q == 3'h0;
    endproperty
    a_prescaler_cleared: assert property (p_prescaler_cleared) // [RQ8]
        else $error("prescaler not cleared by count write");

    property p_overflow_flag;
        @(posedge clk) disable iff (!nrst)
        (ce && ovf && !count_write) |=> status_q[gst_pkg::IRQ_OVF_POS]
            && count_q == gst_pkg::COUNT_RESET;
    endproperty
    a_overflow_flag: assert property (p_overflow_flag) // [RQ18]
        else $error("wrap did not set flag or clear count");

    property p_pin_needs_fall;
        @(posedge clk) disable iff (!nrst)
        (ce && count_write) |=> !armed_q;
    endproperty
    a_pin_needs_fall: assert property (p_pin_needs_fall) // [RQ6]
        else $error("pin edge armed right after count write");

    property p_irq_level;
        @(posedge clk) disable iff (!nrst)
        (ce && |(status_q & mask_q)) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) // [RQ10]
        else $error("interrupt low with unmasked status set");

    property p_ce_freezes;
        @(posedge clk) disable iff (!nrst)
        !ce |=> $stable(count_q) && $stable(status_q) && $stable(ctrl_q);
    endproperty
    a_ce_freezes: assert property (p_ce_freezes)
        else $error("state moved while clock enable low");

    property p_wrap_gate_pulse;
        @(posedge clk) disable iff (!nrst)
        (ce && eight_bit_timer_wrap && !bus.wr
            && gate_source_select == gst_pkg::GSRC_EIGHT_BIT_WRAP) |=> gate_raw;
    endproperty
    a_wrap_gate_pulse: assert property (p_wrap_gate_pulse) // [RQ16] [RQ17]
        else $error("companion wrap did not reach the gate");

    // Pin edge as seen in the selected sync mode, counter ready to take it
    sequence s_pin_edge_seen;
        ce && armed_q && clock_select == gst_pkg::CLK_PIN && run
            && prescale_select == 2'b00 && !count_write
            && (sync_disable ? (pin_clk_s && !pin_prev_q)
                : (pin_prev_q && !pin_old_q));
    endsequence

    property p_pin_edge_counts;
        @(posedge clk) disable iff (!nrst)
        s_pin_edge_seen |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_pin_edge_counts: assert property (p_pin_edge_counts) // [RQ5] [RQ9]
        else $error("pin clock edge not counted");
endmodule : gst_timer

// file: gst_pins_model.sv
/*
 * Far-side model of the timer's pins: pin clock, slow oscillator,
 * gate pin and both comparator outputs.
 * Assumes the bench clock; the bench asks for pin clock runs and levels.
 */
module gst_pins_model (
    // Clock
    input wire logic clk,
    // Requests from the bench
    input wire logic ext_run,
    input wire logic [2:0] levels,
    // Pins towards the timer
    output gst_pkg::gst_pins_type pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] div_q = 4'h0;
    always @(posedge clk) begin
        div_q <= div_q + 4'h1;
    end
    // Pin clock period 8 cycles, low and still outside requested runs
    always_comb begin
        pins.ext_clock_pin = ext_run & div_q[2];
        pins.low_freq_internal_osc = div_q[3];
        pins.gate_pin = levels[0];
        pins.comparator1_out = levels[1];
        pins.comparator2_out = levels[2];
    end
endmodule : gst_pins_model

// file: test_gst_timer.sv
/*
 * Self-checking bench of the gated sixteen-bit timer: table of count
 * rates, then reset, byte access, overflow interrupt and wrap gate tests.
 * Assumes a 25 MHz clock and the strobe register port of the design.
 */
module test_gst_timer;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] gate;
        logic [2:0] lv;
        logic ext;
        logic [15:0] cnt;
    } gst_row_type;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    gst_pkg::gst_bus_req_type bus = '0;
    logic [7:0] rdata;
    gst_pkg::gst_pins_type pins;
    logic wrap = 1'b0;
    logic irq;
    logic ext_run = 1'b0;
    logic [2:0] lv = 3'h0;
    logic [7:0] rv;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int tol = 0;
    gst_row_type rows [14] = '{
        '{8'h41, 8'h00, 3'h0, 1'b0, 16'h0040},
        '{8'h51, 8'h00, 3'h0, 1'b0, 16'h0020},
        '{8'h61, 8'h00, 3'h0, 1'b0, 16'h0010},
        '{8'h71, 8'h00, 3'h0, 1'b0, 16'h0008},
        '{8'h01, 8'h00, 3'h0, 1'b0, 16'h0010},
        '{8'h40, 8'h00, 3'h0, 1'b0, 16'h0000},
        '{8'h41, 8'h80, 3'h1, 1'b0, 16'h0000},
        '{8'h41, 8'hC0, 3'h1, 1'b0, 16'h0040},
        '{8'h41, 8'hC2, 3'h2, 1'b0, 16'h0040},
        '{8'h41, 8'hC3, 3'h0, 1'b0, 16'h0000},
        '{8'h41, 8'h81, 3'h0, 1'b0, 16'h0040},
        '{8'h81, 8'h00, 3'h0, 1'b1, 16'h0008},
        '{8'h85, 8'h00, 3'h0, 1'b1, 16'h0008},
        '{8'hC1, 8'h00, 3'h0, 1'b0, 16'h0004}};

    gst_timer u_gst_timer (.clk(clk), .ce(ce), .nrst(nrst), .bus(bus),
        .rdata(rdata), .pins(pins), .eight_bit_timer_wrap(wrap), .irq(irq));
    gst_pins_model u_gst_pins_model (.clk(clk), .ext_run(ext_run),
        .levels(lv), .pins(pins));

    always #20 clk = ~clk;

    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            stop_test();
        end
    end

    // Window of tol around exp accepts start-up phase of dividers and syncs
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp, input int tol);
        compares++;
        if ($isunknown(seen) || seen + tol < exp || seen > exp + tol) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd

    task automatic load(input logic [7:0] hi, input logic [7:0] lo);
        wr(gst_pkg::ADDR_COUNTER_CONTROL, 8'h00);
        wr(gst_pkg::ADDR_COUNT_HIGH, hi);
        wr(gst_pkg::ADDR_COUNT_LOW, lo);
    endtask : load

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            load(8'h00, 8'h00);
            wr(gst_pkg::ADDR_GATE_CONTROL, rows[i].gate);
            lv <= rows[i].lv;
            ext_run <= rows[i].ext;
            repeat (4) @(posedge clk);
            wr(gst_pkg::ADDR_COUNTER_CONTROL, rows[i].ctrl);
            repeat (64) @(posedge clk);
            wr(gst_pkg::ADDR_COUNTER_CONTROL, rows[i].ctrl & 8'hFE);
            ext_run <= 1'b0;
            rd(gst_pkg::ADDR_COUNT_LOW, rv);
            tol = (rows[i].cnt == 0) ? 0 : 2;
            check("count", {8'h00, rv}, rows[i].cnt, tol);
            $display("row %0d done", i);
        end
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            rd(a[2:0], rv);
            check("reset value", {8'h00, rv}, 16'h0000, 0);
        end
        $display("reset test done");
        load(8'hA5, 8'h3C);
        rd(gst_pkg::ADDR_COUNT_LOW, rv);
        check("count low", {8'h00, rv}, 16'h003C, 0);
        rd(gst_pkg::ADDR_COUNT_HIGH, rv);
        check("count high", {8'h00, rv}, 16'h00A5, 0);
        $display("byte access test done");
        wr(gst_pkg::ADDR_GATE_CONTROL, 8'h00);
        for (int m = 1; m >= 0; m--) begin
            wr(gst_pkg::ADDR_IRQ_MASK, m[7:0]);
            load(8'hFF, 8'hFD);
            wr(gst_pkg::ADDR_COUNTER_CONTROL, 8'h41);
            repeat (6) @(posedge clk);
            wr(gst_pkg::ADDR_COUNTER_CONTROL, 8'h40);
            check("irq", {15'h0000, irq}, m[15:0], 0);
            rd(gst_pkg::ADDR_COUNT_HIGH, rv);
            check("wrapped high", {8'h00, rv}, 16'h0000, 0);
            rd(gst_pkg::ADDR_IRQ_STATUS, rv);
            check("status set", {8'h00, rv}, 16'h0001, 0);
            rd(gst_pkg::ADDR_IRQ_STATUS, rv);
            check("status cleared", {8'h00, rv}, 16'h0000, 0);
            repeat (2) @(posedge clk);
            check("irq cleared", {15'h0000, irq}, 16'h0000, 0);
        end
        $display("overflow test done");
        // Clock enable low for 20 cycles; only the two enabled edges count
        load(8'h00, 8'h00);
        wr(gst_pkg::ADDR_COUNTER_CONTROL, 8'h41);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        wr(gst_pkg::ADDR_COUNTER_CONTROL, 8'h40);
        rd(gst_pkg::ADDR_COUNT_LOW, rv);
        check("clock enable hold", {8'h00, rv}, 16'h0002, 0);
        $display("clock enable test done");
        load(8'h00, 8'h00);
        wr(gst_pkg::ADDR_GATE_CONTROL, 8'hC1);
        wr(gst_pkg::ADDR_COUNTER_CONTROL, 8'h41);
        repeat (5) begin
            repeat (3) @(posedge clk);
            wrap <= 1'b1;
            @(posedge clk);
            wrap <= 1'b0;
        end
        repeat (4) @(posedge clk);
        wr(gst_pkg::ADDR_COUNTER_CONTROL, 8'h40);
        rd(gst_pkg::ADDR_COUNT_LOW, rv);
        check("wrap gated count", {8'h00, rv}, 16'h0005, 1);
        $display("wrap gate test done");
        stop_test();
    end
endmodule : test_gst_timer
